// *** rtl/dlr_pkg.sv ***
package dlr_pkg;

   // ---------------------------------------------------------------
   // Command blocks
   // ---------------------------------------------------------------
   localparam int CDB_BYTES = 12;
   localparam logic [7:0] OP_SHORT = 8'h37;
   localparam logic [7:0] OP_LONG = 8'hb7;
   localparam int SH_SEL_BYTE = 2;
   localparam int SH_ALLOC_MSB = 7;
   localparam int SH_ALLOC_LSB = 8;
   localparam int LG_SEL_BYTE = 1;
   localparam int LG_ALLOC_B0 = 6;
   localparam int LG_ALLOC_B1 = 7;
   localparam int LG_ALLOC_B2 = 8;
   localparam int LG_ALLOC_B3 = 9;
   localparam int SEL_P_BIT = 4;
   localparam int SEL_G_BIT = 3;
   localparam int SEL_FMT_MSB = 2;
   localparam logic [2:0] FMT_BYTES_FROM_INDEX = 3'b100;
   localparam logic [2:0] FMT_PHYS_SECTOR = 3'b101;
   localparam logic [1:0] PG_HDR_ONLY = 2'b00;
   localparam logic [1:0] PG_GROWN = 2'b01;
   localparam logic [1:0] PG_FACTORY = 2'b10;
   localparam logic [1:0] PG_ALL = 2'b11;

   // ---------------------------------------------------------------
   // Returned list layout
   // ---------------------------------------------------------------
   localparam logic [3:0] HDR_SHORT = 4'h4;
   localparam logic [3:0] HDR_LONG = 4'h8;
   localparam logic [3:0] HB_SEL = 4'h1;
   localparam logic [3:0] HB_SH_LEN_MSB = 4'h2;
   localparam logic [3:0] HB_SH_LEN_LSB = 4'h3;
   localparam logic [3:0] HB_LG_LEN_B0 = 4'h4;
   localparam logic [3:0] HB_LG_LEN_B1 = 4'h5;
   localparam logic [3:0] HB_LG_LEN_B2 = 4'h6;
   localparam logic [3:0] HB_LG_LEN_B3 = 4'h7;
   localparam int LIST_CNT_W = 29;
   localparam logic [2:0] DSC_SHIFT_ZERO = 3'b000;

   // ---------------------------------------------------------------
   // Status
   // ---------------------------------------------------------------
   localparam logic [3:0] SK_RECOVERED = 4'h1;
   localparam logic [7:0] ASC_BAD_FORMAT = 8'h1c;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SEND = 3'b010,
      ST_DRAIN = 3'b100
   } dlr_state_e;

   typedef logic [CDB_BYTES-1:0][7:0] dlr_cdb_t;

   typedef struct packed {
      logic [LIST_CNT_W-1:0] grown_cnt;
      logic [LIST_CNT_W-1:0] factory_cnt;
      logic [LIST_CNT_W-1:0] all_cnt;
      logic list_ok;
      logic medium_err;
   } dlr_lists_s;

   typedef struct packed {
      logic [7:0] data;
      logic valid;
      logic last;
   } dlr_din_s;

   typedef struct packed {
      logic done;
      logic [7:0] status;
      logic [3:0] key;
      logic [7:0] asc;
   } dlr_done_s;

   typedef struct packed {
      dlr_state_e st;
      logic rdy;
      logic long_cmd;
      logic [7:0] sel;
      logic fmt_bad;
      logic [31:0] list_len;
      logic [3:0] hdr_len;
      logic [3:0] hdr_pos;
      logic [31:0] left;
      logic [31:0] dsc_addr;
      dlr_din_s din;
      dlr_done_s fin;
   } dlr_regs_s;

endpackage : dlr_pkg

// *** rtl/dlr_hdr_byte.sv ***
`timescale 1ns/1ps
module dlr_hdr_byte
   import dlr_pkg::*;
(
   input wire logic long_cmd,
   input wire logic [7:0] sel,
   input wire logic [31:0] list_len,
   input wire logic [3:0] pos,
   output logic [7:0] hbyte
);

   always_comb begin
      hbyte = 8'h00;
      if (pos == HB_SEL) begin
         hbyte = sel;
      end else if (!long_cmd) begin
         if (pos == HB_SH_LEN_MSB) begin
            hbyte = list_len[15:8];
         end else if (pos == HB_SH_LEN_LSB) begin
            hbyte = list_len[7:0];
         end
      end else begin
         unique case (pos)
            HB_LG_LEN_B0: hbyte = list_len[31:24];
            HB_LG_LEN_B1: hbyte = list_len[23:16];
            HB_LG_LEN_B2: hbyte = list_len[15:8];
            HB_LG_LEN_B3: hbyte = list_len[7:0];
            default: hbyte = 8'h00;
         endcase
      end
   end

endmodule : dlr_hdr_byte

// *** rtl/dlr_responder.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Stop data-in after the smaller of host buffer limit and available bytes.
// - Zero host buffer limit sends no bytes and is not an error.
// - Short command returns a 4-byte header echoing delivered selection and format.
// - List length is full available size; truncation neither adjusts it nor errors.
// - Short header bytes 2-3 hold list length, eight per defect, MSB first.
// - Selection 00 header only, 01 grown, 10 factory_defect_list, 11 all lists.
// - Selection 00 reports zero length and sends no descriptor bytes.
// - Format 100 is bytes-from-index, 101 is physical-sector.
// - Other formats send physical-sector, then check condition key 1h, code 1Ch.
// - Descriptors may come in any order; no ordering is imposed.
// - Long command is B7h, 12 bytes; byte 1 holds selection and format.
// - Long command host buffer limit is bytes 6-9, MSB first.
// - Long command is refused with reservation conflict if reserved by another port.
// - Extent reservations never block the long command.
// - Long command returns an 8-byte header; length in bytes 4-7.
// - Short command is 37h, 10 bytes; selection byte 2, limit bytes 7-8.
// - Unreachable defect data ends with check condition, list-not-found.
module dlr_responder
   import dlr_pkg::*;
#(
   parameter logic [7:0] STATUS_GOOD = 8'h00,
   parameter logic [7:0] STATUS_CHECK = 8'h02,
   parameter logic [7:0] STATUS_RESV_CONFLICT = 8'h18,
   parameter logic [3:0] SK_NO_SENSE = 4'h0,
   parameter logic [3:0] SK_MEDIUM_ERROR = 4'h3,
   parameter logic [7:0] ASC_LIST_NOT_FOUND = 8'h19
)
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire dlr_cdb_t cmd_cdb,
   output logic cmd_ready,
   input wire logic lun_reserved_other,
   input wire dlr_lists_s lists,
   output logic [31:0] dsc_addr,
   input wire logic [7:0] dsc_data,
   output dlr_din_s din,
   input wire logic din_ready,
   output dlr_done_s fin
);

   dlr_regs_s s_r;
   dlr_regs_s s_nxt;

   logic [7:0] op;
   logic is_long;
   logic [7:0] req_sel;
   logic [2:0] fmt_out;
   logic fmt_ok;
   logic [31:0] host_buffer_limit;
   logic [LIST_CNT_W-1:0] cnt;
   logic [31:0] len_sel;
   logic [3:0] hdr_sel;
   logic [32:0] total;
   logic [31:0] xfer;
   logic [7:0] hbyte;
   logic take;

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   assign op = cmd_cdb[0];
   assign is_long = (op == OP_LONG);
   assign take = s_r.rdy && cmd_valid && ((op == OP_LONG) || (op == OP_SHORT));
   assign req_sel = is_long ? cmd_cdb[LG_SEL_BYTE] : cmd_cdb[SH_SEL_BYTE];
   assign host_buffer_limit = is_long ?
      {cmd_cdb[LG_ALLOC_B0], cmd_cdb[LG_ALLOC_B1], cmd_cdb[LG_ALLOC_B2], cmd_cdb[LG_ALLOC_B3]} :
      {16'h0000, cmd_cdb[SH_ALLOC_MSB], cmd_cdb[SH_ALLOC_LSB]};
   assign fmt_ok = (req_sel[SEL_FMT_MSB:0] == FMT_BYTES_FROM_INDEX) ||
                   (req_sel[SEL_FMT_MSB:0] == FMT_PHYS_SECTOR);
   assign fmt_out = fmt_ok ? req_sel[SEL_FMT_MSB:0] : FMT_PHYS_SECTOR;

   always_comb begin
      unique case ({req_sel[SEL_P_BIT], req_sel[SEL_G_BIT]})
         PG_HDR_ONLY: cnt = '0;
         PG_GROWN: cnt = lists.grown_cnt;
         PG_FACTORY: cnt = lists.factory_cnt;
         PG_ALL: cnt = lists.all_cnt;
      endcase
   end

   // Full available size, never reduced by the host limit
   assign len_sel = {cnt, DSC_SHIFT_ZERO};
   assign hdr_sel = is_long ? HDR_LONG : HDR_SHORT;
   assign total = {1'b0, len_sel} + {29'h0, hdr_sel};
   assign xfer = ({1'b0, host_buffer_limit} < total) ? host_buffer_limit : total[31:0];

   dlr_hdr_byte u_hdr (
      .long_cmd(s_r.long_cmd),
      .sel(s_r.sel),
      .list_len(s_r.list_len),
      .pos(s_r.hdr_pos),
      .hbyte(hbyte)
   );

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.fin.done = 1'b0;
      unique case (s_r.st)
         ST_IDLE: begin
            if (take) begin
               s_nxt.long_cmd = is_long;
               s_nxt.sel = {3'b000, req_sel[SEL_P_BIT], req_sel[SEL_G_BIT], fmt_out};
               s_nxt.fmt_bad = !fmt_ok;
               s_nxt.list_len = len_sel;
               s_nxt.hdr_len = hdr_sel;
               s_nxt.hdr_pos = 4'h0;
               s_nxt.dsc_addr = 32'h0000_0000;
               s_nxt.left = xfer;
               s_nxt.fin.key = SK_NO_SENSE;
               s_nxt.fin.asc = 8'h00;
               // Only the logical unit reservation is looked at here
               if (is_long && lun_reserved_other) begin
                  s_nxt.fin.done = 1'b1;
                  s_nxt.fin.status = STATUS_RESV_CONFLICT;
               end else if ((cnt != '0 || req_sel[SEL_P_BIT] || req_sel[SEL_G_BIT]) &&
                            !lists.list_ok) begin
                  s_nxt.fin.done = 1'b1;
                  s_nxt.fin.status = STATUS_CHECK;
                  s_nxt.fin.key = lists.medium_err ? SK_MEDIUM_ERROR : SK_NO_SENSE;
                  s_nxt.fin.asc = ASC_LIST_NOT_FOUND;
               end else if (xfer == 32'h0000_0000) begin
                  s_nxt.fin.done = 1'b1;
                  s_nxt.fin.status = fmt_ok ? STATUS_GOOD : STATUS_CHECK;
                  s_nxt.fin.key = fmt_ok ? SK_NO_SENSE : SK_RECOVERED;
                  s_nxt.fin.asc = fmt_ok ? 8'h00 : ASC_BAD_FORMAT;
               end else begin
                  s_nxt.rdy = 1'b0;
                  s_nxt.st = ST_SEND;
               end
            end
         end
         ST_SEND: begin
            if (!s_r.din.valid || din_ready) begin
               s_nxt.din.valid = 1'b1;
               if (s_r.hdr_pos < s_r.hdr_len) begin
                  s_nxt.din.data = hbyte;
                  s_nxt.hdr_pos = s_r.hdr_pos + 4'h1;
               end else begin
                  // Descriptor bytes pass in stored order, unsorted
                  s_nxt.din.data = dsc_data;
                  s_nxt.dsc_addr = s_r.dsc_addr + 32'h0000_0001;
               end
               s_nxt.left = s_r.left - 32'h0000_0001;
               s_nxt.din.last = (s_r.left == 32'h0000_0001);
               if (s_r.left == 32'h0000_0001) begin
                  s_nxt.st = ST_DRAIN;
               end
            end
         end
         ST_DRAIN: begin
            if (din_ready) begin
               s_nxt.din.valid = 1'b0;
               s_nxt.din.last = 1'b0;
               s_nxt.rdy = 1'b1;
               s_nxt.st = ST_IDLE;
               s_nxt.fin.done = 1'b1;
               // Truncation is never an error; only a bad format is
               s_nxt.fin.status = s_r.fmt_bad ? STATUS_CHECK : STATUS_GOOD;
               s_nxt.fin.key = s_r.fmt_bad ? SK_RECOVERED : SK_NO_SENSE;
               s_nxt.fin.asc = s_r.fmt_bad ? ASC_BAD_FORMAT : 8'h00;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s_r <= '{st: ST_IDLE, rdy: 1'b1, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cmd_ready = s_r.rdy;
   assign dsc_addr = s_r.dsc_addr;
   assign din = s_r.din;
   assign fin = s_r.fin;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   logic [31:0] beats_r;
   logic [31:0] cap_r;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         beats_r <= 32'h0000_0000;
         cap_r <= 32'h0000_0000;
      end else if (take) begin
         beats_r <= 32'h0000_0000;
         cap_r <= host_buffer_limit;
      end else if (din.valid && din_ready) begin
         beats_r <= beats_r + 32'h0000_0001;
      end
   end

   sequence seq_last_taken;
      din.valid && din.last && din_ready;
   endsequence

   sequence seq_resv_cmd;
      take && is_long && lun_reserved_other;
   endsequence

   a_last_then_done: assert property (seq_last_taken |=> fin.done)
      else $error("done did not follow the last byte");
   a_beats_within_limit: assert property (din.valid |-> beats_r < cap_r)
      else $error("byte offered beyond host buffer limit");
   a_zero_limit_none: assert property (take && host_buffer_limit == 32'h0 |=> !din.valid [*2])
      else $error("bytes sent with zero host buffer limit");
   a_hdr_sel_byte: assert property (din.valid && beats_r == 32'h1 |-> din.data == s_r.sel)
      else $error("header selection byte wrong");
   a_short_len_msb: assert property (din.valid && !s_r.long_cmd && beats_r == 32'h2
                                     |-> din.data == s_r.list_len[15:8])
      else $error("short header length byte wrong");
   a_long_len_msb: assert property (din.valid && s_r.long_cmd && beats_r == 32'h4
                                    |-> din.data == s_r.list_len[31:24])
      else $error("long header length byte wrong");
   a_hdr_only_len: assert property (s_r.st == ST_SEND &&
                                    s_r.sel[SEL_P_BIT:SEL_G_BIT] == PG_HDR_ONLY
                                    |-> s_r.list_len == 32'h0 && s_r.dsc_addr == 32'h0)
      else $error("header-only request carried descriptors");
   a_fmt_default: assert property (s_r.fmt_bad && !s_r.rdy
                                   |-> s_r.sel[SEL_FMT_MSB:0] == FMT_PHYS_SECTOR)
      else $error("bad format not replaced by physical sector");
   a_fmt_status: assert property (fin.done && s_r.fmt_bad && fin.status != STATUS_RESV_CONFLICT
                                  && fin.asc != ASC_LIST_NOT_FOUND
                                  |-> fin.status == STATUS_CHECK && fin.key == SK_RECOVERED
                                      && fin.asc == ASC_BAD_FORMAT)
      else $error("bad format status wrong");
   a_resv_conflict: assert property (seq_resv_cmd |=> fin.done &&
                                     fin.status == STATUS_RESV_CONFLICT && !din.valid)
      else $error("reservation conflict not reported");

endmodule : dlr_responder

// *** bench/dlr_initiator_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Far-side model: descriptor store and data sink
// ---------------------------------------------------------------
module dlr_init_model
   import dlr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic slow,
   input wire logic [31:0] dsc_addr,
   output logic [7:0] dsc_data,
   output logic din_ready
);
   logic [1:0] cyc_r;
   initial begin
      cyc_r = 2'h0;
      din_ready = 1'b1;
   end
   // Sink holds din_ready low one cycle in four when slow is set and never alters bytes
   always @(negedge clk_sys) begin
      cyc_r <= cyc_r + 2'h1;
      din_ready <= !(slow && cyc_r == 2'h1);
   end
   assign dsc_data = dsc_addr[7:0] ^ 8'ha5;
endmodule : dlr_init_model

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   import dlr_pkg::*;
   logic clk_sys, resetn, cmd_valid, cmd_ready, lun_reserved_other, din_ready, slow;
   dlr_cdb_t cmd_cdb;
   dlr_lists_s lists;
   logic [31:0] dsc_addr;
   logic [7:0] dsc_data;
   dlr_din_s din;
   dlr_done_s fin;
   logic [7:0] rx[$];
   logic lastq[$];
   int fail_count = 0, checks = 0, cycles = 0, tnum = 0;

   dlr_responder u_dlr_responder (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
      .cmd_cdb(cmd_cdb), .cmd_ready(cmd_ready), .lun_reserved_other(lun_reserved_other),
      .lists(lists), .dsc_addr(dsc_addr), .dsc_data(dsc_data), .din(din),
      .din_ready(din_ready), .fin(fin));
   dlr_init_model u_dlr_init_model (.clk_sys(clk_sys), .slow(slow), .dsc_addr(dsc_addr),
      .dsc_data(dsc_data), .din_ready(din_ready));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (din.valid === 1'b1 && din_ready === 1'b1) begin
         rx.push_back(din.data);
         lastq.push_back(din.last);
      end
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   function automatic dlr_cdb_t mk(input bit lg, input logic [7:0] sel, input logic [31:0] lim);
      dlr_cdb_t c;
      c = '0;
      if (lg) begin
         c[0] = OP_LONG;
         c[LG_SEL_BYTE] = sel;
         {c[6], c[7], c[8], c[9]} = lim;
      end else begin
         c[0] = OP_SHORT;
         c[SH_SEL_BYTE] = sel;
         {c[7], c[8]} = lim[15:0];
      end
      return c;
   endfunction : mk

   // Issue one command, collect the stream, compare header, data and status
   task automatic run(input bit lg, input logic [1:0] pg, input logic [2:0] f,
         input logic [31:0] lim, input logic resv);
      int cnt, tot, hdr, n;
      logic [31:0] len;
      logic [2:0] fd;
      logic [7:0] st, ac, ex;
      logic [3:0] ky;
      logic [7:0] hb[8];
      cnt = (pg == PG_HDR_ONLY) ? 0 : (pg == PG_GROWN) ? int'(lists.grown_cnt) :
         (pg == PG_FACTORY) ? int'(lists.factory_cnt) : int'(lists.all_cnt);
      len = 32'(8 * cnt);
      hdr = lg ? 8 : 4;
      fd = (f == FMT_BYTES_FROM_INDEX || f == FMT_PHYS_SECTOR) ? f : FMT_PHYS_SECTOR;
      tot = 0;
      ky = 4'h0;
      ac = 8'h00;
      if (lg && resv) begin
         st = 8'h18;
      end else if (pg != PG_HDR_ONLY && !lists.list_ok) begin
         st = 8'h02;
         ky = lists.medium_err ? 4'h3 : 4'h0;
         ac = 8'h19;
      end else begin
         tot = (lim < 32'(hdr + 8 * cnt)) ? int'(lim) : hdr + 8 * cnt;
         st = (fd != f) ? 8'h02 : 8'h00;
         ky = (fd != f) ? SK_RECOVERED : 4'h0;
         ac = (fd != f) ? ASC_BAD_FORMAT : 8'h00;
      end
      if (lg) begin
         hb = '{8'h00, {3'h0, pg, fd}, 8'h00, 8'h00, len[31:24], len[23:16], len[15:8], len[7:0]};
      end else begin
         hb = '{8'h00, {3'h0, pg, fd}, len[15:8], len[7:0], 8'h00, 8'h00, 8'h00, 8'h00};
      end
      rx.delete();
      lastq.delete();
      @(negedge clk_sys);
      lun_reserved_other = resv;
      cmd_cdb = mk(lg, {3'h0, pg, f}, lim);
      cmd_valid = 1'b1;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      n = 0;
      while (fin.done !== 1'b1 && n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      check(32'(fin.done), 32'h1);
      check(32'(fin.status), 32'(st));
      check({fin.key, fin.asc}, {ky, ac});
      check(32'(rx.size()), 32'(tot));
      for (int i = 0; i < rx.size(); i++) begin
         ex = (i < hdr) ? hb[i] : 8'((i - hdr) ^ 8'ha5);
         check(32'(rx[i]), 32'(ex));
         check(32'(lastq[i]), 32'(i == tot - 1));
      end
      if (tot > 0 && rx.size() == tot) begin
         check(32'(lastq[tot-1]), 32'h1);
      end
      tnum++;
      $display("test %0d finished", tnum);
   endtask : run

   initial begin
      resetn = 1'b0;
      cmd_valid = 1'b0;
      cmd_cdb = '0;
      lun_reserved_other = 1'b0;
      slow = 1'b0;
      lists = '{grown_cnt: 29'h2, factory_cnt: 29'h3, all_cnt: 29'h6, list_ok: 1'b1,
         medium_err: 1'b0};
      repeat (20) @(negedge clk_sys);
      resetn = 1'b1;
      check({31'h0, cmd_ready}, 32'h1);
      check(32'(fin), 32'h0);
      check(32'(din), 32'h0);
      check(dsc_addr, 32'h0);
      // Unknown opcode is neither taken nor answered
      @(negedge clk_sys);
      cmd_cdb = '0;
      cmd_cdb[0] = 8'h3e;
      cmd_valid = 1'b1;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      check({31'h0, cmd_ready}, 32'h1);
      check({31'h0, fin.done}, 32'h0);
      @(negedge clk_sys);
      check({31'h0, fin.done}, 32'h0);
      check(32'(din), 32'h0);
      for (int p = 0; p < 4; p++) begin
         run(1'b0, 2'(p), FMT_PHYS_SECTOR, 32'h64, 1'b0);
      end
      for (int f = 0; f < 8; f++) begin
         run(1'b0, PG_GROWN, 3'(f), 32'h28, 1'b0);
      end
      slow = 1'b1;
      run(1'b0, PG_ALL, FMT_PHYS_SECTOR, 32'h5, 1'b0);
      run(1'b0, PG_GROWN, FMT_BYTES_FROM_INDEX, 32'h0, 1'b0);
      run(1'b0, PG_GROWN, 3'h0, 32'h0, 1'b0);
      run(1'b0, PG_FACTORY, FMT_PHYS_SECTOR, 32'h64, 1'b1);
      run(1'b1, PG_ALL, FMT_PHYS_SECTOR, 32'h0001_0000, 1'b0);
      run(1'b1, PG_FACTORY, 3'h7, 32'hc, 1'b0);
      run(1'b1, PG_GROWN, FMT_BYTES_FROM_INDEX, 32'h64, 1'b1);
      run(1'b1, PG_HDR_ONLY, FMT_PHYS_SECTOR, 32'h64, 1'b0);
      slow = 1'b0;
      lists.list_ok = 1'b0;
      lists.medium_err = 1'b1;
      run(1'b0, PG_GROWN, FMT_PHYS_SECTOR, 32'h64, 1'b0);
      lists.medium_err = 1'b0;
      run(1'b1, PG_ALL, FMT_PHYS_SECTOR, 32'h64, 1'b0);
      run(1'b0, PG_HDR_ONLY, FMT_PHYS_SECTOR, 32'h64, 1'b0);
      summarize();
   end
endmodule : testbench
